// ===== logic/led_key_serial_controller.sv
// led_key_serial_controller: serial command interpreter, display memory, key readout
`timescale 1ns/1ps
// Functional notes
// R1 - first byte per frame is instruction, B7:B6
// R2 - frame select high aborts partial byte
// R3 - data command: write 00, read 10 only
// R4 - display control: pulse width code, on bit
// R5 - byte bit n drives segment n+1
// R6 - even addresses feed digit phases one to eight
// R7 - scan three returns by eight scan lines
// R8 - key bytes one to four, LSB first
// R9 - pressed key reads as one
// R10 - byte n packs lines 2n-1 and 2n
// R11 - at most four key bytes per frame
// R12 - host reads key bytes strictly in order
// R13 - combinations only within one scan line
// R14 - autonomous scan once per display cycle
// R15 - first pressed key wins within cycle
// R16 - segment outputs double as scan lines
// R17 - sample serial input on rising clock
// R18 - host waits before first read clock
// R19 - auto increment stores consecutive data bytes
// R20 - host order: data, address+data, control
// R21 - fixed mode: one byte per address command
// R22 - read frame returns four key bytes
// R23 - host raises frame select between blocks
// R24 - drive data line only while sending keys
// R25 - receive bytes LSB first
// R26 - ignore data while address at 10H or above
module led_key_serial_controller #(
    parameter int DISPLAY_CYCLES = led_key_pkg::DISPLAY_CYCLE_CYC
) (
    // system clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // serial link
    input  wire logic       serial_clk,
    input  wire logic       frame_select,
    input  wire logic       bidir_serial_line_in,
    output logic            bidir_serial_line_out,
    output logic            bidir_serial_line_oe_n,
    // display and keypad pins
    output logic [7:0]      segment_outputs,
    output logic [7:0]      digit_select_outputs,
    input  wire logic [2:0] key_return_inputs
);
    logic        link_rst;
    logic [2:0]  bit_cnt_reg,   bit_cnt_next;
    logic [6:0]  shift_reg,     shift_next;
    logic        first_reg,     first_next;
    logic        read_mode_reg, read_mode_next;
    logic [7:0]  rx_byte_reg,   rx_byte_next;
    logic        rx_first_reg,  rx_first_next;
    logic        rx_tgl_reg,    rx_tgl_next;
    logic [5:0]  tx_cnt_reg,    tx_cnt_next;
    logic        tx_bit_reg,    tx_bit_next;
    logic        tx_drive_reg,  tx_drive_next;
    logic [7:0]  full_byte;
    logic        byte_done;
    logic [31:0] key_snap_reg,  key_snap_next;

    led_key_pkg::cmd_state_t state_reg, state_next;
    logic        tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
    logic        frm_s1_reg, frm_s2_reg;
    logic [2:0]  ret_s1_reg, ret_s2_reg;
    logic        byte_evt, is_instr, data_evt, wr_en;
    logic        write_mode_reg, write_mode_next;
    logic        fixed_reg,      fixed_next;
    logic [4:0]  addr_reg,       addr_next;
    logic        disp_on_reg,    disp_on_next;
    logic [2:0]  pulse_reg,      pulse_next;
    logic [7:0]  mem_reg [led_key_pkg::NUM_ADDR];
    logic [7:0]  mem_next [led_key_pkg::NUM_ADDR];
    logic [127:0] mem_flat;

    scan_if bus_if ();

    // link side: the frame select itself ends every frame, sclk may stop
    assign link_rst = frame_select | reset;

    always_comb begin
        full_byte      = {bidir_serial_line_in, shift_reg}; // R25
        byte_done      = (bit_cnt_reg == 3'h7) && !read_mode_reg;
        bit_cnt_next   = bit_cnt_reg + 3'h1;
        shift_next     = full_byte[7:1];
        first_next     = first_reg & ~byte_done;
        read_mode_next = read_mode_reg;
        rx_byte_next   = rx_byte_reg;
        rx_first_next  = rx_first_reg;
        rx_tgl_next    = rx_tgl_reg;
        if (byte_done) begin
            rx_byte_next  = full_byte;
            rx_first_next = first_reg; // R1
            rx_tgl_next   = ~rx_tgl_reg;
            if (first_reg && (full_byte[7:6] == led_key_pkg::TYPE_DATA) &&
                (full_byte[1:0] == led_key_pkg::DMODE_READ)) begin
                read_mode_next = 1'b1; // R22
            end
        end
    end

    always_ff @(posedge serial_clk or posedge link_rst) begin // R17 R2
        if (link_rst) begin
            bit_cnt_reg   <= 3'h0;
            shift_reg     <= 7'h00;
            first_reg     <= 1'b1;
            read_mode_reg <= 1'b0;
        end else begin
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            first_reg     <= first_next;
            read_mode_reg <= read_mode_next;
        end
    end

    // the held byte outlives the frame so the system side can still take it
    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) begin
            rx_byte_reg  <= 8'h00;
            rx_first_reg <= 1'b0;
            rx_tgl_reg   <= 1'b0;
        end else begin
            rx_byte_reg  <= rx_byte_next;
            rx_first_reg <= rx_first_next;
            rx_tgl_reg   <= rx_tgl_next;
        end
    end

    // key snapshot is frozen well before the first read edge, so it is quasi-static here
    always_comb begin
        tx_cnt_next   = tx_cnt_reg;
        tx_bit_next   = tx_bit_reg;
        tx_drive_next = 1'b0;
        if (read_mode_reg && (tx_cnt_reg < 6'(led_key_pkg::KEY_BITS))) begin // R11
            tx_bit_next   = key_snap_reg[tx_cnt_reg[4:0]]; // R8
            tx_drive_next = 1'b1; // R24
            tx_cnt_next   = tx_cnt_reg + 6'h01;
        end
    end

    always_ff @(negedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            tx_cnt_reg   <= 6'h00;
            tx_bit_reg   <= 1'b0;
            tx_drive_reg <= 1'b0;
        end else begin
            tx_cnt_reg   <= tx_cnt_next;
            tx_bit_reg   <= tx_bit_next;
            tx_drive_reg <= tx_drive_next;
        end
    end

    assign bidir_serial_line_out  = tx_bit_reg;
    assign bidir_serial_line_oe_n = ~tx_drive_reg;

    // system side synchronisers; the second stages are looked at, and tgl_s3_reg too for the toggle edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
            frm_s1_reg <= 1'b1;
            frm_s2_reg <= 1'b1;
            ret_s1_reg <= 3'h0;
            ret_s2_reg <= 3'h0;
        end else begin
            tgl_s1_reg <= rx_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
            frm_s1_reg <= frame_select;
            frm_s2_reg <= frm_s1_reg;
            ret_s1_reg <= key_return_inputs;
            ret_s2_reg <= ret_s1_reg;
        end
    end

    always_comb begin
        byte_evt        = tgl_s2_reg ^ tgl_s3_reg;
        is_instr        = rx_first_reg || (state_reg != led_key_pkg::ST_DATA);
        data_evt        = byte_evt && !is_instr;
        wr_en           = data_evt && write_mode_reg && !addr_reg[4];
        state_next      = state_reg;
        write_mode_next = write_mode_reg;
        fixed_next      = fixed_reg;
        addr_next       = addr_reg;
        disp_on_next    = disp_on_reg;
        pulse_next      = pulse_reg;
        mem_next        = mem_reg;
        if (byte_evt && is_instr) begin
            unique case (rx_byte_reg[7:6])
                led_key_pkg::TYPE_DATA: begin
                    state_next = led_key_pkg::ST_INSTR;
                    // codes 01 and 11 leave the mode untouched
                    if (rx_byte_reg[1:0] == led_key_pkg::DMODE_WRITE) begin // R3
                        write_mode_next = 1'b1;
                        fixed_next      = rx_byte_reg[led_key_pkg::BIT_FIXED];
                    end else if (rx_byte_reg[1:0] == led_key_pkg::DMODE_READ) begin
                        write_mode_next = 1'b0;
                        state_next      = led_key_pkg::ST_READ; // R22
                    end
                end
                led_key_pkg::TYPE_DISP: begin
                    pulse_next   = rx_byte_reg[2:0]; // R4
                    disp_on_next = rx_byte_reg[led_key_pkg::BIT_DISP_ON];
                end
                led_key_pkg::TYPE_ADDR: begin
                    addr_next  = {|rx_byte_reg[5:4], rx_byte_reg[3:0]}; // R19 R21
                    state_next = led_key_pkg::ST_DATA;
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
        if (wr_en) begin
            mem_next[addr_reg[3:0]] = rx_byte_reg; // R5 R26
        end
        if (data_evt && !fixed_reg && !addr_reg[4]) begin
            addr_next = addr_reg + 5'h01; // R19
        end
        if (data_evt && fixed_reg) begin
            state_next = led_key_pkg::ST_INSTR; // R21
        end
        if (frm_s2_reg) begin
            state_next = led_key_pkg::ST_INSTR; // R2
        end
        key_snap_next = key_snap_reg;
        if (state_reg != led_key_pkg::ST_READ) begin
            for (int n = 0; n < led_key_pkg::KEY_BYTES; n++) begin
                key_snap_next[8*n +: 8] = {1'b0, bus_if.key_lines[6*n+3 +: 3],
                                           1'b0, bus_if.key_lines[6*n +: 3]}; // R10
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg      <= led_key_pkg::ST_INSTR;
            write_mode_reg <= 1'b1;
            fixed_reg      <= 1'b0;
            addr_reg       <= led_key_pkg::ADDR_RESET;
            disp_on_reg    <= 1'b0;
            pulse_reg      <= led_key_pkg::PULSE_RESET;
            key_snap_reg   <= 32'h00000000;
            for (int a = 0; a < led_key_pkg::NUM_ADDR; a++) begin
                mem_reg[a] <= 8'h00;
            end
        end else begin
            state_reg      <= state_next;
            write_mode_reg <= write_mode_next;
            fixed_reg      <= fixed_next;
            addr_reg       <= addr_next;
            disp_on_reg    <= disp_on_next;
            pulse_reg      <= pulse_next;
            key_snap_reg   <= key_snap_next;
            mem_reg        <= mem_next;
        end
    end

    // odd addresses would feed the two extra segments, which are not built
    always_comb begin
        for (int i = 0; i < led_key_pkg::NUM_DIGITS; i++) begin
            bus_if.seg_data[8*i +: 8] = mem_reg[2*i]; // R6
        end
        for (int a = 0; a < led_key_pkg::NUM_ADDR; a++) begin
            mem_flat[8*a +: 8] = mem_reg[a];
        end
        bus_if.pulse_code = pulse_reg;
        bus_if.display_on = disp_on_reg;
        bus_if.key_ret    = ret_s2_reg;
    end

    key_scan_mux #(
        .DISPLAY_CYCLES(DISPLAY_CYCLES)
    ) u_scan (
        .mclk                 (mclk),
        .reset                (reset),
        .bus                  (bus_if.scan),
        .segment_outputs      (segment_outputs),
        .digit_select_outputs (digit_select_outputs)
    );

    AST_DISP_CTRL: assert property (@(posedge mclk) disable iff (reset) // R4
        byte_evt && is_instr && rx_byte_reg[7:6] == led_key_pkg::TYPE_DISP |=>
        disp_on_reg == $past(rx_byte_reg[3]) && pulse_reg == $past(rx_byte_reg[2:0]))
        else $error("display control not taken");
    AST_ADDR_CMD: assert property (@(posedge mclk) disable iff (reset) // R1
        byte_evt && is_instr && rx_byte_reg[7:6] == led_key_pkg::TYPE_ADDR && !frm_s2_reg
        |=> state_reg == led_key_pkg::ST_DATA && addr_reg[3:0] == $past(rx_byte_reg[3:0]))
        else $error("address command not taken");
    AST_MEM_WRITE: assert property (@(posedge mclk) disable iff (reset) // R5
        wr_en |=> mem_reg[$past(addr_reg[3:0])] == $past(rx_byte_reg))
        else $error("display byte not stored");
    AST_AUTO_INC: assert property (@(posedge mclk) disable iff (reset) // R19
        wr_en && !fixed_reg |=> addr_reg == $past(addr_reg) + 5'h01)
        else $error("address did not advance");
    AST_FIXED_ONE: assert property (@(posedge mclk) disable iff (reset) // R21
        data_evt && fixed_reg |=> state_reg == led_key_pkg::ST_INSTR)
        else $error("fixed mode accepted a second data byte");
    AST_HIGH_ADDR: assert property (@(posedge mclk) disable iff (reset) // R26
        data_evt && addr_reg[4] |=> $stable(mem_flat))
        else $error("write above 0FH changed memory");
    AST_BAD_MODE: assert property (@(posedge mclk) disable iff (reset) // R3
        byte_evt && is_instr && rx_byte_reg[7:6] == led_key_pkg::TYPE_DATA && rx_byte_reg[0]
        |=> $stable(write_mode_reg) && $stable(fixed_reg))
        else $error("illegal data command changed mode");
    AST_FRAME_END: assert property (@(posedge mclk) disable iff (reset) // R2
        frm_s2_reg |=> state_reg == led_key_pkg::ST_INSTR)
        else $error("frame end did not return to instruction");
    AST_SNAP_HOLD: assert property (@(posedge mclk) disable iff (reset) // R12
        state_reg == led_key_pkg::ST_READ ##1 state_reg == led_key_pkg::ST_READ
        |-> $stable(key_snap_reg))
        else $error("key snapshot moved during read");
    AST_SNAP_ZERO: assert property (@(posedge mclk) disable iff (reset) // R10
        (key_snap_reg & 32'h88888888) == 32'h00000000)
        else $error("unused key status bit set");
    AST_OE_READ: assert property (@(negedge serial_clk) disable iff (link_rst) // R24
        !bidir_serial_line_oe_n |-> read_mode_reg && tx_cnt_reg <= 6'h20)
        else $error("data line driven outside key readout");
    COV_READ: cover property (@(posedge mclk) disable iff (reset)
        state_reg == led_key_pkg::ST_READ ##1 frm_s2_reg);
    COV_AUTO: cover property (@(posedge mclk) disable iff (reset)
        wr_en && !fixed_reg && addr_reg == 5'h0f);
    COV_FIXED: cover property (@(posedge mclk) disable iff (reset)
        wr_en && fixed_reg);
endmodule

// ===== pkg/led_key_pkg.sv
// led_key_pkg: constants and types shared by the serial command side and the scan side
package led_key_pkg;
    // timing
    localparam int MCLK_PERIOD_NS    = 4;
    localparam int DISPLAY_CYCLE_NS  = 4_700_000;
    localparam int DISPLAY_CYCLE_CYC = DISPLAY_CYCLE_NS / MCLK_PERIOD_NS;
    localparam int READ_WAIT_NS      = 2000;
    // multiplex geometry
    localparam int         NUM_DIGITS      = 8;
    localparam int         SLOTS_PER_PHASE = 16;
    localparam logic [3:0] KEY_SLOT        = 4'hf;
    localparam int         NUM_ADDR        = 16;
    localparam int         KEY_BYTES       = 4;
    localparam int         KEY_BITS        = 32;
    // instruction fields
    localparam logic [1:0] TYPE_DATA   = 2'h1;
    localparam logic [1:0] TYPE_DISP   = 2'h2;
    localparam logic [1:0] TYPE_ADDR   = 2'h3;
    localparam logic [1:0] DMODE_WRITE = 2'h0;
    localparam logic [1:0] DMODE_READ  = 2'h2;
    localparam int         BIT_FIXED   = 2;
    localparam int         BIT_DISP_ON = 3;
    // reset values
    localparam logic [4:0] ADDR_RESET  = 5'h00;
    localparam logic [2:0] PULSE_RESET = 3'h0;
    // on-time in sixteenths per pulse code, code 0 in the low nibble
    localparam logic [31:0] PULSE_SIXTEENTHS = 32'hedcba421;

    typedef enum logic [2:0] {
        ST_INSTR = 3'b001,
        ST_DATA  = 3'b010,
        ST_READ  = 3'b100
    } cmd_state_t;
endpackage

// ===== pkg/scan_if.sv
// scan_if: state shared between the command side and the scan side
`timescale 1ns/1ps
interface scan_if;
    logic [63:0] seg_data;
    logic [2:0]  pulse_code;
    logic        display_on;
    logic [2:0]  key_ret;
    logic [23:0] key_lines;

    modport ctrl (
        output seg_data,
        output pulse_code,
        output display_on,
        output key_ret,
        input  key_lines
    );
    modport scan (
        input  seg_data,
        input  pulse_code,
        input  display_on,
        input  key_ret,
        output key_lines
    );
endinterface

// ===== logic/key_scan_mux.sv
// key_scan_mux: digit multiplexing, brightness slots and key matrix scan
`timescale 1ns/1ps
module key_scan_mux #(
    parameter int DISPLAY_CYCLES = led_key_pkg::DISPLAY_CYCLE_CYC
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  reset,
    // shared state
    scan_if.scan       bus,
    // pins
    output logic [7:0] segment_outputs,
    output logic [7:0] digit_select_outputs
);
    localparam int SLOT_RAW = DISPLAY_CYCLES /
        (led_key_pkg::NUM_DIGITS * led_key_pkg::SLOTS_PER_PHASE);
    localparam int SLOT_CYC = (SLOT_RAW < 1) ? 1 : SLOT_RAW;
    localparam int TW       = $clog2(SLOT_CYC + 1);

    logic [TW-1:0] tick_reg,  tick_next;
    logic [3:0]    slot_reg,  slot_next;
    logic [2:0]    phase_reg, phase_next;
    logic [7:0]    seg_reg,   seg_next;
    logic [7:0]    dig_reg,   dig_next;
    logic [23:0]   acc_reg,   acc_next;
    logic [23:0]   lines_reg, lines_next;
    logic [2:0]    sel_reg,   sel_next;
    logic          held_reg,  held_next;
    logic [7:0]    hits;
    logic [2:0]    pick;
    logic [3:0]    width;

    always_comb begin
        tick_next  = tick_reg + TW'(1);
        slot_next  = slot_reg;
        phase_next = phase_reg;
        acc_next   = acc_reg;
        lines_next = lines_reg;
        sel_next   = sel_reg;
        held_next  = held_reg;
        hits       = '0;
        pick       = '0;
        seg_next   = '0;
        dig_next   = '0;
        width      = led_key_pkg::PULSE_SIXTEENTHS[4*bus.pulse_code +: 4];
        // the last slot is never lit, so scanning cannot steal display time
        if (slot_reg == led_key_pkg::KEY_SLOT) begin
            seg_next = 8'h01 << phase_reg; // R16
        end else if (bus.display_on && (slot_reg < width)) begin // R4
            dig_next = 8'h01 << phase_reg;
            seg_next = bus.seg_data[8*phase_reg +: 8]; // R6
        end
        if (tick_reg == TW'(SLOT_CYC - 1)) begin
            tick_next = '0;
            slot_next = slot_reg + 4'h1;
            if (slot_reg == led_key_pkg::KEY_SLOT) begin
                // return 3 lands lowest, so each line reads K3 K2 K1 upward
                acc_next[3*phase_reg +: 3] = {bus.key_ret[0], bus.key_ret[1],
                                              bus.key_ret[2]}; // R7 R9 R10
                phase_next = phase_reg + 3'h1;
                if (phase_reg == 3'h7) begin // R14
                    for (int i = 7; i >= 0; i--) begin
                        hits[i] = |acc_next[3*i +: 3];
                        if (hits[i]) begin
                            pick = 3'(i);
                        end
                    end
                    // a line already reported wins over later presses
                    if (held_reg && hits[sel_reg]) begin // R15
                        pick = sel_reg;
                    end
                    lines_next = '0;
                    lines_next[3*pick +: 3] = acc_next[3*pick +: 3]; // R13
                    sel_next  = pick;
                    held_next = |hits;
                    acc_next  = '0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_reg  <= '0;
            slot_reg  <= 4'h0;
            phase_reg <= 3'h0;
            seg_reg   <= 8'h00;
            dig_reg   <= 8'h00;
            acc_reg   <= 24'h000000;
            lines_reg <= 24'h000000;
            sel_reg   <= 3'h0;
            held_reg  <= 1'b0;
        end else begin
            tick_reg  <= tick_next;
            slot_reg  <= slot_next;
            phase_reg <= phase_next;
            seg_reg   <= seg_next;
            dig_reg   <= dig_next;
            acc_reg   <= acc_next;
            lines_reg <= lines_next;
            sel_reg   <= sel_next;
            held_reg  <= held_next;
        end
    end

    assign segment_outputs      = seg_reg;
    assign digit_select_outputs = dig_reg;
    assign bus.key_lines        = lines_reg;

    AST_DISP_OFF: assert property (@(posedge mclk) disable iff (reset) // R4
        !bus.display_on |=> digit_select_outputs == 8'h00)
        else $error("digit lit while display off");
    AST_KEY_SLOT: assert property (@(posedge mclk) disable iff (reset) // R16
        slot_reg == led_key_pkg::KEY_SLOT |=> (digit_select_outputs == 8'h00) &&
        (segment_outputs == (8'h01 << $past(phase_reg))))
        else $error("scan slot does not drive one scan line");
    AST_ONE_LINE: assert property (@(posedge mclk) disable iff (reset) // R13
        $onehot0({|lines_reg[21+:3], |lines_reg[18+:3], |lines_reg[15+:3],
        |lines_reg[12+:3], |lines_reg[9+:3], |lines_reg[6+:3],
        |lines_reg[3+:3], |lines_reg[0+:3]}))
        else $error("keys of two scan lines reported together");
    COV_KEY_SEEN: cover property (@(posedge mclk) disable iff (reset)
        bus.key_lines != 24'h000000);
endmodule

// ===== testbench/host_link.sv
// host_link: host side of the three-wire link, 15 ns bit clock
`timescale 1ns/1ps
module host_link (
    // link pins
    output logic      serial_clk,
    output logic      frame_select,
    output logic      line_level,
    // device data pin
    input  wire logic dev_out,
    input  wire logic dev_oe_n
);
    logic host_drive;
    logic host_bit;
    logic float_bit = 1'b0;
    // released line: no pull, so show a level that keeps changing
    always @(serial_clk) float_bit <= !float_bit;
    always_comb line_level = !dev_oe_n ? dev_out : (host_drive ? host_bit : float_bit);
    initial begin
        serial_clk = 1'b1;
        frame_select = 1'b1;
        host_drive = 1'b0;
        host_bit = 1'b0;
    end
    task automatic open_frame();
        frame_select = 1'b0;
        #500;
    endtask
    task automatic close_frame();
        #500;
        host_drive = 1'b0;
        frame_select = 1'b1;
        #1000;
    endtask
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b0;
            host_drive = 1'b1;
            host_bit = b[i];
            #7.5 serial_clk = 1'b1;
            #7.5;
        end
    endtask
    task automatic get_byte(output logic [7:0] b, output logic [7:0] oe);
        host_drive = 1'b0;
        for (int i = 0; i < 8; i++) begin
            serial_clk = 1'b0;
            #7.5 serial_clk = 1'b1;
            b[i] = line_level;
            oe[i] = dev_oe_n;
            #7.5;
        end
    endtask
endmodule

// ===== testbench/led_key_serial_controller_bench.sv
// led_key_serial_controller_bench: host frames against a behavioural model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module led_key_serial_controller_bench;
    logic       mclk, reset, sclk, fsel, lvl, dout, oe_n, chk_en, fixed, wr_mode, want_instr;
    logic [2:0] key_ret;
    logic [7:0] seg, dig, q[$];
    logic [7:0] mem[16];
    logic [2:0] pressed[8];
    logic [31:0] rnd;
    int         err_total, total_checks, addr, kept, l1, l2;
    int         wid[8] = '{1, 2, 4, 10, 11, 12, 13, 14};
    led_key_serial_controller #(.DISPLAY_CYCLES(1280)) dut (.mclk(mclk), .reset(reset),
        .serial_clk(sclk), .frame_select(fsel), .bidir_serial_line_in(lvl),
        .bidir_serial_line_out(dout), .bidir_serial_line_oe_n(oe_n), .segment_outputs(seg),
        .digit_select_outputs(dig), .key_return_inputs(key_ret));
    host_link host (.serial_clk(sclk), .frame_select(fsel), .line_level(lvl), .dev_out(dout),
        .dev_oe_n(oe_n));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    always @(negedge mclk) begin
        logic [2:0] r;
        r = 3'h0;
        for (int l = 0; l < 8; l++) if (seg[l] && dig === 8'h00) r |= pressed[l];
        key_ret <= r;
        if (fsel) `CHK("idle oe_n", 1'b1, oe_n)
        if (chk_en && dig !== 8'h00) for (int i = 0; i < 8; i++)
            if (dig[i]) `CHK("segments", mem[2*i], seg)
    end
    task automatic model(input logic [7:0] b, input bit first);
        if (first || want_instr) begin
            want_instr = b[7:6] != 2'h3;
            if (b[7:6] == 2'h1 && b[1:0] == 2'h0) {wr_mode, fixed} = {1'b1, b[2]};
            if (b[7:6] == 2'h1 && b[1:0] == 2'h2) wr_mode = 1'b0;
            if (b[7:6] == 2'h3) addr = b[5:0];
        end else begin
            want_instr = fixed;
            if (wr_mode && addr < 16) mem[addr] = b;
            if (wr_mode && addr < 16 && !fixed) addr++;
        end
    endtask
    task automatic frame(input logic [7:0] f[$]);
        chk_en = 1'b0;
        host.open_frame();
        foreach (f[i]) begin
            host.put_bits(f[i], 8);
            model(f[i], i == 0);
        end
        host.close_frame();
        chk_en = 1'b1;
    endtask
    task automatic bright(input logic [7:0] c, input int e);
        int n;
        n = 0;
        frame('{c});
        repeat (1280) @(negedge mclk);
        repeat (1280) begin
            @(negedge mclk);
            if (dig !== 8'h00) n++;
        end
        `CHK("on cycles", e, n)
    endtask
    task automatic press(input int l, input logic [2:0] m);
        logic [7:0] b, oe;
        logic [31:0] e;
        pressed[l] = m;
        repeat (3840) @(negedge mclk);
        if (kept < 0 || pressed[kept] == 3'h0) begin
            kept = -1;
            for (int i = 7; i >= 0; i--) if (pressed[i] != 3'h0) kept = i;
        end
        e = 32'h0;
        if (kept >= 0) e[4*kept+:3] =
            {pressed[kept][0], pressed[kept][1], pressed[kept][2]};
        host.open_frame();
        host.put_bits(8'h42, 8);
        model(8'h42, 1'b1);
        #2000;
        for (int n = 0; n < 5; n++) begin
            host.get_byte(b, oe);
            if (n < 4) begin
                `CHK("key byte", e[8*n+:8], b)
                `CHK("read oe_n", 8'h00, oe)
            end else `CHK("oe_n after four", 8'hff, oe)
        end
        host.close_frame();
    endtask
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400_000;
        err_total++;
        end_of_test();
    end
    initial begin
        {reset, chk_en, fixed, wr_mode, want_instr} = 5'h13;
        {err_total, total_checks, addr, kept, rnd} = {32'h0, 32'h0, 32'h0, -32'sd1, 32'he1a3};
        foreach (mem[i]) mem[i] = 8'h00;
        foreach (pressed[i]) pressed[i] = 3'h0;
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        q = '{8'h40, 8'hc0};
        repeat (16) begin
            rnd = lfsr(rnd);
            q.push_back(rnd[7:0]);
        end
        frame(q);
        frame('{8'h8f});
        repeat (2560) @(negedge mclk);
        frame('{8'h44, 8'hc2, 8'h3f, 8'hc4, 8'h01});
        chk_en = 1'b0;
        host.open_frame();
        host.put_bits(8'hc6, 8);
        model(8'hc6, 1'b1);
        host.put_bits(8'h00, 5);
        host.close_frame();
        frame('{8'h40, 8'hce, 8'ha5, 8'h5a, 8'h77});
        frame('{8'hde, 8'h11});
        for (int c = 0; c < 8; c++) bright(8'h88 | c[7:0], 80 * wid[c]);
        bright(8'h80, 0);
        frame('{8'h8f});
        rnd = lfsr(rnd);
        l1 = rnd[2:0];
        l2 = (l1 + 1 + rnd[4:3]) % 8;
        press(l1, rnd[7:5] | 3'h1);
        press(l2, 3'h7);
        press(l1, 3'h0);
        frame('{8'h41, 8'hc0, 8'h55});
        frame('{8'h43, 8'hc2, 8'h66});
        repeat (1280) @(negedge mclk);
        end_of_test();
    end
endmodule
